//--- hdl/mms_consts.svh
`ifndef MMS_CONSTS_SVH
`define MMS_CONSTS_SVH
// Station address range.
`define MMS_STATION_MIN 8'h01
`define MMS_STATION_MAX 8'hf7
// Function codes.
`define MMS_FN_RD_COIL  8'h01
`define MMS_FN_RD_REG   8'h03
`define MMS_FN_WR_COIL  8'h05
`define MMS_FN_WR_REG   8'h06
// Boolean write values.
`define MMS_COIL_ON     16'hff00
`define MMS_COIL_OFF    16'h0000
// Boolean map: entries 0040h to 0100h.
`define MMS_COIL_BASE   16'h0040
`define MMS_COIL_LAST   16'h0100
`define MMS_COIL_NUM    193
`define MMS_COIL_QTY_MAX 16'h00c1
// Word map: 20000 to 20127.
`define MMS_REG_BASE    16'h4e20
`define MMS_REG_LAST    16'h4e9f
`define MMS_REG_NUM     128
`define MMS_REG_QTY_MAX 16'h007d
// Frame layout.
`define MMS_REQ_LEN     4'h8
`define MMS_HDR_LEN     9'h003
`define MMS_RD_OVERHEAD 9'h005
// Checksum.
`define MMS_CRC_INIT    16'hffff
`define MMS_CRC_POLY    16'ha001
// Reply wait of the master.
`define MMS_CLK_MHZ     10
`define MMS_REPLY_WAIT_US 100
`define MMS_REPLY_WAIT_CYC (`MMS_REPLY_WAIT_US * `MMS_CLK_MHZ)
`endif

//--- hdl/mms_pkg.sv
`include "mms_consts.svh"
package mms_pkg;
    // Byte on the link.
    typedef logic [7:0] mms_byte_t;
    // Device sequencer states.
    typedef enum logic [1:0] {
        D_RX    = 2'b00,
        D_CHECK = 2'b01,
        D_EXEC  = 2'b10,
        D_TX    = 2'b11
    } mms_dev_state_t;
    // Master sequencer states.
    typedef enum logic [1:0] {
        H_IDLE = 2'b00,
        H_SEND = 2'b01,
        H_WAIT = 2'b10
    } mms_host_state_t;
    // One byte step of the reflected checksum, low bit first.
    function automatic logic [15:0] mms_crc_step(input logic [15:0] crc, input mms_byte_t data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `MMS_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction
endpackage

//--- hdl/mms_link_if.sv
`timescale 1ns/100ps
// Byte link between master and device; one byte per valid cycle.
interface mms_link_if (
    input wire logic clock
);
    logic              m2s_valid;  // Master byte strobe.
    mms_pkg::mms_byte_t m2s_data;  // Master byte.
    logic              m2s_last;   // Last byte of a request.
    logic              s2m_valid;  // Device byte strobe.
    mms_pkg::mms_byte_t s2m_data;  // Device byte.
    logic              s2m_last;   // Last byte of a reply.
    modport dev  (input m2s_valid, m2s_data, m2s_last, output s2m_valid, s2m_data, s2m_last);
    modport host (output m2s_valid, m2s_data, m2s_last, input s2m_valid, s2m_data, s2m_last);
endinterface

//--- hdl/mms_host.sv
`timescale 1ns/100ps
`include "mms_consts.svh"
// Master end: frames one request, collects the reply.
module mms_host (
    // Clock and reset.
    input  wire logic                clock,
    input  wire logic                reset,
    // Link toward the device.
    mms_link_if.host                 link,
    // Command side.
    input  wire logic                cmd_valid,
    input  wire mms_pkg::mms_byte_t  cmd_station,
    input  wire mms_pkg::mms_byte_t  cmd_func,
    input  wire logic [15:0]         cmd_addr,
    input  wire logic [15:0]         cmd_value,
    output logic                     cmd_ready,
    // Reply side.
    output logic                     rsp_valid,
    output mms_pkg::mms_byte_t       rsp_data,
    output logic                     rsp_last,
    output logic                     rsp_crc_ok,
    output logic                     rsp_timeout
);
    import mms_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    mms_host_state_t state, next_state;     // Sequencer.
    mms_byte_t       req [0:5];             // Latched request body.
    mms_byte_t       next_req [0:5];
    logic [2:0]      idx, next_idx;         // Byte being sent.
    logic [15:0]     crc, next_crc;         // Running checksum.
    logic [10:0]     wait_cnt, next_wait_cnt; // Reply wait timer.
    logic            next_cmd_ready, next_rsp_valid, next_rsp_last;
    logic            next_crc_ok, next_timeout, next_m2s_valid, next_m2s_last;
    mms_byte_t       next_rsp_data, next_m2s_data;

    // Next values: one command at a time; writes are never batched.
    always_comb begin
        next_state = state;
        next_req = req;
        next_idx = idx;
        next_crc = crc;
        next_wait_cnt = wait_cnt;
        next_cmd_ready = 1'b0;
        next_rsp_valid = 1'b0;
        next_rsp_data = rsp_data;
        next_rsp_last = 1'b0;
        next_crc_ok = 1'b0;
        next_timeout = 1'b0;
        next_m2s_valid = 1'b0;
        next_m2s_data = link.m2s_data;
        next_m2s_last = 1'b0;
        case (state)
            H_IDLE: begin
                next_cmd_ready = 1'b1;
                // Only legal station numbers go out on the link.
                if (cmd_valid && cmd_station >= `MMS_STATION_MIN
                    && cmd_station <= `MMS_STATION_MAX) begin
                    next_req[0] = cmd_station;
                    next_req[1] = cmd_func;
                    next_req[2] = cmd_addr[15:8];
                    next_req[3] = cmd_addr[7:0];
                    next_req[4] = cmd_value[15:8];
                    next_req[5] = cmd_value[7:0];
                    next_idx = 3'h0;
                    next_crc = `MMS_CRC_INIT;
                    next_cmd_ready = 1'b0;
                    next_state = H_SEND;
                end
            end
            H_SEND: begin
                next_m2s_valid = 1'b1;
                next_idx = idx + 3'h1;
                if (idx == 3'h6) begin
                    next_m2s_data = crc[7:0];
                end else if (idx == 3'h7) begin
                    next_m2s_data = crc[15:8];
                    next_m2s_last = 1'b1;
                    next_crc = `MMS_CRC_INIT;
                    next_wait_cnt = 11'h000;
                    next_state = H_WAIT;
                end else begin
                    next_m2s_data = req[idx];
                    next_crc = mms_crc_step(crc, req[idx]);
                end
            end
            H_WAIT: begin
                next_wait_cnt = wait_cnt + 11'h001;
                if (link.s2m_valid) begin
                    next_rsp_valid = 1'b1;
                    next_rsp_data = link.s2m_data;
                    next_crc = mms_crc_step(crc, link.s2m_data);
                    // A good frame leaves a zero residue after its own checksum.
                    if (link.s2m_last) begin
                        next_rsp_last = 1'b1;
                        next_crc_ok = (mms_crc_step(crc, link.s2m_data) == 16'h0000);
                        next_cmd_ready = 1'b1;
                        next_state = H_IDLE;
                    end
                end else if (wait_cnt == 11'(`MMS_REPLY_WAIT_CYC)) begin
                    // The device drops bad frames silently, so give up.
                    next_timeout = 1'b1;
                    next_cmd_ready = 1'b1;
                    next_state = H_IDLE;
                end
            end
            default: begin
                next_state = H_IDLE;
            end
        endcase
    end

    // Registers.
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= H_IDLE;
            for (int i = 0; i < 6; i++) begin
                req[i] <= 8'h00;
            end
            idx <= 3'h0;
            crc <= `MMS_CRC_INIT;
            wait_cnt <= 11'h000;
            cmd_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_last <= 1'b0;
            rsp_crc_ok <= 1'b0;
            rsp_timeout <= 1'b0;
            link.m2s_valid <= 1'b0;
            link.m2s_data <= 8'h00;
            link.m2s_last <= 1'b0;
        end else begin
            state <= next_state;
            req <= next_req;
            idx <= next_idx;
            crc <= next_crc;
            wait_cnt <= next_wait_cnt;
            cmd_ready <= next_cmd_ready;
            rsp_valid <= next_rsp_valid;
            rsp_data <= next_rsp_data;
            rsp_last <= next_rsp_last;
            rsp_crc_ok <= next_crc_ok;
            rsp_timeout <= next_timeout;
            link.m2s_valid <= next_m2s_valid;
            link.m2s_data <= next_m2s_data;
            link.m2s_last <= next_m2s_last;
        end
    end
endmodule

//--- hdl/mms_device.sv
`timescale 1ns/100ps
`include "mms_consts.svh"
module mms_device (
    // Clock and reset.
    input  wire logic                clock,
    input  wire logic                reset,
    // Link toward the master.
    mms_link_if.dev                  link,
    // Own station number.
    input  wire mms_pkg::mms_byte_t  station_id,
    // Image refresh from the downstream poller.
    input  wire logic                load_valid,
    input  wire logic                load_coil,
    input  wire logic [15:0]         load_addr,
    input  wire logic [15:0]         load_value,
    // Writes forwarded to the downstream slave.
    output logic                     fwd_valid,
    output logic                     fwd_coil,
    output logic [15:0]              fwd_addr,
    output logic [15:0]              fwd_value
);
    import mms_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    mms_dev_state_t state, next_state;          // Sequencer.
    mms_byte_t      rx_buf [0:7];               // Received request.
    mms_byte_t      next_rx_buf [0:7];
    logic [3:0]     rx_cnt, next_rx_cnt;        // Bytes seen in this frame.
    logic [15:0]    rx_crc, next_rx_crc;        // Residue over the frame.
    logic [8:0]     tx_idx, next_tx_idx;        // Reply byte index.
    logic [15:0]    tx_crc, next_tx_crc;        // Reply checksum.
    logic [`MMS_COIL_NUM-1:0] coils, next_coils; // Boolean image.
    logic [15:0]    regs [0:`MMS_REG_NUM-1];    // Word image.
    logic [15:0]    next_regs [0:`MMS_REG_NUM-1];
    logic           next_s2m_valid, next_s2m_last;
    mms_byte_t      next_s2m_data;
    logic           next_fwd_valid, next_fwd_coil;
    logic [15:0]    next_fwd_addr, next_fwd_value;

    // ----------------------------------------
    // Request decode
    // ----------------------------------------
    mms_byte_t   fn;            // Function code.
    logic [15:0] f_addr;        // Entry address, big-endian.
    logic [15:0] f_val;         // Value or count, big-endian.
    logic [15:0] f_end;         // Last entry touched by a read.
    logic [15:0] coil_idx;      // Entry offset in the boolean image.
    logic [15:0] reg_idx;       // Entry offset in the word image.
    logic        req_ok;        // Frame may be acted on.
    mms_byte_t   rd_bytes;      // Data bytes in a read reply.
    logic [8:0]  tx_len;        // Total reply length.
    logic        echo;          // Reply repeats the request.

    // Field extraction and validity.
    always_comb begin
        fn = rx_buf[1];
        f_addr = {rx_buf[2], rx_buf[3]};
        f_val = {rx_buf[4], rx_buf[5]};
        f_end = f_addr + f_val - 16'h0001;
        coil_idx = f_addr - `MMS_COIL_BASE;
        reg_idx = f_addr - `MMS_REG_BASE;
        echo = (fn == `MMS_FN_WR_COIL) || (fn == `MMS_FN_WR_REG);
        case (fn)
            `MMS_FN_WR_COIL: req_ok = f_addr >= `MMS_COIL_BASE && f_addr <= `MMS_COIL_LAST
                && (f_val == `MMS_COIL_ON || f_val == `MMS_COIL_OFF);
            `MMS_FN_WR_REG: req_ok = f_addr >= `MMS_REG_BASE && f_addr <= `MMS_REG_LAST;
            `MMS_FN_RD_REG: req_ok = f_val != 16'h0000 && f_val <= `MMS_REG_QTY_MAX
                && f_addr >= `MMS_REG_BASE && f_end <= `MMS_REG_LAST;
            `MMS_FN_RD_COIL: req_ok = f_val != 16'h0000 && f_val <= `MMS_COIL_QTY_MAX
                && f_addr >= `MMS_COIL_BASE && f_end <= `MMS_COIL_LAST;
            default: req_ok = 1'b0;
        endcase
        // Only our own legal station and an intact checksum are served.
        if (rx_buf[0] != station_id || station_id < `MMS_STATION_MIN
            || station_id > `MMS_STATION_MAX || rx_crc != 16'h0000) begin
            req_ok = 1'b0;
        end
        // Two bytes per word; booleans rounded up to whole bytes.
        if (fn == `MMS_FN_RD_REG) begin
            rd_bytes = {f_val[6:0], 1'b0};
        end else begin
            rd_bytes = (f_val[7:0] + 8'h07) >> 3;
        end
        tx_len = echo ? 9'({`MMS_REQ_LEN}) : ({1'b0, rd_bytes} + `MMS_RD_OVERHEAD);
    end

    // ----------------------------------------
    // Reply byte
    // ----------------------------------------
    mms_byte_t   tx_byte;   // Byte due at tx_idx.
    logic [8:0]  k;         // Data byte number.
    logic [15:0] word;      // Word being sent.
    logic [7:0]  pos;       // Boolean offset from start.

    // Echo replays the stored frame, checksum included.
    always_comb begin
        k = tx_idx - `MMS_HDR_LEN;
        word = regs[7'(reg_idx[6:0] + k[7:1])];
        pos = 8'h00;
        tx_byte = 8'h00;
        if (echo) begin
            tx_byte = rx_buf[tx_idx[2:0]];
        end else if (tx_idx == 9'h000 || tx_idx == 9'h001) begin
            tx_byte = rx_buf[tx_idx[2:0]];
        end else if (tx_idx == 9'h002) begin
            tx_byte = rd_bytes;
        end else if (tx_idx == tx_len - 9'h002) begin
            tx_byte = tx_crc[7:0];
        end else if (tx_idx == tx_len - 9'h001) begin
            tx_byte = tx_crc[15:8];
        end else if (fn == `MMS_FN_RD_REG) begin
            tx_byte = k[0] ? word[7:0] : word[15:8];
        end else begin
            // Lowest entry in bit 0; bits past the count read as zero.
            for (int j = 0; j < 8; j++) begin
                pos = {k[4:0], 3'b000} + 8'(j);
                if (pos < f_val[7:0]) begin
                    tx_byte[j] = coils[8'(coil_idx[7:0] + pos)];
                end
            end
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Next values for the whole block; bytes arriving outside receive are ignored.
    always_comb begin
        next_state = state;
        next_rx_buf = rx_buf;
        next_rx_cnt = rx_cnt;
        next_rx_crc = rx_crc;
        next_tx_idx = tx_idx;
        next_tx_crc = tx_crc;
        next_coils = coils;
        next_regs = regs;
        next_s2m_valid = 1'b0;
        next_s2m_data = link.s2m_data;
        next_s2m_last = 1'b0;
        next_fwd_valid = 1'b0;
        next_fwd_coil = fwd_coil;
        next_fwd_addr = fwd_addr;
        next_fwd_value = fwd_value;
        // Poller refresh; a master write in the same cycle lands after it.
        if (load_valid) begin
            if (load_coil && load_addr >= `MMS_COIL_BASE && load_addr <= `MMS_COIL_LAST) begin
                next_coils[8'(load_addr - `MMS_COIL_BASE)] = (load_value != 16'h0000);
            end else if (!load_coil && load_addr >= `MMS_REG_BASE
                         && load_addr <= `MMS_REG_LAST) begin
                next_regs[7'(load_addr - `MMS_REG_BASE)] = load_value;
            end
        end
        case (state)
            D_RX: begin
                if (link.m2s_valid) begin
                    if (rx_cnt < `MMS_REQ_LEN) begin
                        next_rx_buf[rx_cnt[2:0]] = link.m2s_data;
                    end
                    if (rx_cnt != 4'hf) begin
                        next_rx_cnt = rx_cnt + 4'h1;
                    end
                    next_rx_crc = mms_crc_step(rx_crc, link.m2s_data);
                    if (link.m2s_last) begin
                        // Only eight-byte requests are meaningful here.
                        if (rx_cnt == `MMS_REQ_LEN - 4'h1) begin
                            next_state = D_CHECK;
                        end else begin
                            next_rx_cnt = 4'h0;
                            next_rx_crc = `MMS_CRC_INIT;
                        end
                    end
                end
            end
            D_CHECK: begin
                next_rx_cnt = 4'h0;
                next_tx_idx = 9'h000;
                next_tx_crc = `MMS_CRC_INIT;
                if (req_ok) begin
                    next_state = D_EXEC;
                end else begin
                    next_rx_crc = `MMS_CRC_INIT;
                    next_state = D_RX;
                end
            end
            D_EXEC: begin
                // Apply the write and pass it downstream.
                if (fn == `MMS_FN_WR_COIL) begin
                    next_coils[coil_idx[7:0]] = (f_val == `MMS_COIL_ON);
                end else if (fn == `MMS_FN_WR_REG) begin
                    next_regs[reg_idx[6:0]] = f_val;
                end
                next_fwd_valid = echo;
                next_fwd_coil = (fn == `MMS_FN_WR_COIL);
                next_fwd_addr = f_addr;
                next_fwd_value = f_val;
                next_state = D_TX;
            end
            D_TX: begin
                next_s2m_valid = 1'b1;
                next_s2m_data = tx_byte;
                next_tx_idx = tx_idx + 9'h001;
                if (tx_idx < tx_len - 9'h002) begin
                    next_tx_crc = mms_crc_step(tx_crc, tx_byte);
                end
                if (tx_idx == tx_len - 9'h001) begin
                    next_s2m_last = 1'b1;
                    next_rx_crc = `MMS_CRC_INIT;
                    next_state = D_RX;
                end
            end
            default: begin
                next_state = D_RX;
            end
        endcase
    end

    // Registers; the images clear on reset.
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= D_RX;
            for (int i = 0; i < 8; i++) begin
                rx_buf[i] <= 8'h00;
            end
            rx_cnt <= 4'h0;
            rx_crc <= `MMS_CRC_INIT;
            tx_idx <= 9'h000;
            tx_crc <= `MMS_CRC_INIT;
            coils <= '0;
            for (int i = 0; i < `MMS_REG_NUM; i++) begin
                regs[i] <= 16'h0000;
            end
            link.s2m_valid <= 1'b0;
            link.s2m_data <= 8'h00;
            link.s2m_last <= 1'b0;
            fwd_valid <= 1'b0;
            fwd_coil <= 1'b0;
            fwd_addr <= 16'h0000;
            fwd_value <= 16'h0000;
        end else begin
            state <= next_state;
            rx_buf <= next_rx_buf;
            rx_cnt <= next_rx_cnt;
            rx_crc <= next_rx_crc;
            tx_idx <= next_tx_idx;
            tx_crc <= next_tx_crc;
            coils <= next_coils;
            regs <= next_regs;
            link.s2m_valid <= next_s2m_valid;
            link.s2m_data <= next_s2m_data;
            link.s2m_last <= next_s2m_last;
            fwd_valid <= next_fwd_valid;
            fwd_coil <= next_fwd_coil;
            fwd_addr <= next_fwd_addr;
            fwd_value <= next_fwd_value;
        end
    end
endmodule

//--- testbench/mms_link_props.sv
`timescale 1ns/100ps
// ------------------------------
// Byte link checker
// ------------------------------
module mms_link_props (
    // Clock and reset.
    input logic               clock,
    input logic               reset,
    // Both directions of the link.
    input logic               m2s_valid,
    input mms_pkg::mms_byte_t m2s_data,
    input logic               m2s_last,
    input logic               s2m_valid,
    input mms_pkg::mms_byte_t s2m_data,
    input logic               s2m_last
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    // A reply starts eleven cycles after the first request byte.
    a_reply_cause: assert property (
        $rose(s2m_valid) |-> $past(m2s_last, 4) && $past(m2s_valid, 11))
        else $error("Reply without a request.");
    a_station_echo: assert property (
        $rose(s2m_valid) |-> s2m_data == $past(m2s_data, 11))
        else $error("Reply station differs.");
    a_func_echo: assert property (
        $rose(s2m_valid) |=> s2m_data == $past(m2s_data, 11))
        else $error("Reply function differs.");
    // Writes replay the request.
    a_write_echo: assert property (
        $rose(s2m_valid) && $past(m2s_data, 10) inside {8'h05, 8'h06}
        |-> (s2m_valid && s2m_data == $past(m2s_data, 11)) [*8])
        else $error("Write reply is not an echo.");
    a_write_length: assert property (
        $rose(s2m_valid) && $past(m2s_data, 10) inside {8'h05, 8'h06}
        |-> !s2m_last [*7] ##1 s2m_last)
        else $error("Write reply length wrong.");
    a_read_count: assert property (
        $rose(s2m_valid) && $past(m2s_data, 10) == 8'h03
        |-> ##2 s2m_data == 8'($past(m2s_data, 8) << 1))
        else $error("Read byte count wrong.");
    a_reply_gapless: assert property (
        s2m_valid && !s2m_last |=> s2m_valid)
        else $error("Gap inside a reply.");
    a_last_ends: assert property (
        s2m_last |-> s2m_valid ##1 !s2m_valid)
        else $error("Reply runs past its last byte.");
    c_coil_write: cover property ($rose(s2m_valid) && $past(m2s_data, 10) == 8'h05);
    c_word_write: cover property ($rose(s2m_valid) && $past(m2s_data, 10) == 8'h06);
    c_word_read: cover property ($rose(s2m_valid) && $past(m2s_data, 10) == 8'h03);
endmodule

//--- testbench/modbus_mapping_slave_responder_test.sv
`timescale 1ns/100ps
module modbus_mapping_slave_responder_test;
    import mms_pkg::*;
    // ------------------------------
    // Clock, reset and both ends
    // ------------------------------
    logic        clock = 1'b0, reset = 1'b1, cmd_valid = 1'b0;
    logic        load_valid = 1'b0, load_coil = 1'b0, fwd2_valid;
    mms_byte_t   station = 8'h01, cmd_station = 8'h00, cmd_func = 8'h00;
    logic [15:0] cmd_addr = 16'h0000, cmd_value = 16'h0000;
    logic [15:0] load_addr = 16'h0000, load_value = 16'h0000;
    logic        cmd_ready, rsp_valid, rsp_last, rsp_crc_ok, rsp_timeout, fwd_valid, fwd_coil;
    mms_byte_t   rsp_data;
    logic [15:0] fwd_addr, fwd_value;
    int          errors = 0, cmp_count = 0, cycles = 0;
    mms_byte_t   want[$];  // Expected reply bytes.
    mms_byte_t   got[$];   // Reply bytes seen.
    always #50 clock = ~clock;
    mms_link_if link (.clock(clock));
    // Second link driven by the bench.
    mms_link_if link_b (.clock(clock));
    mms_host i_mms_host (.clock, .reset, .link, .cmd_valid, .cmd_station, .cmd_func,
        .cmd_addr, .cmd_value, .cmd_ready, .rsp_valid, .rsp_data, .rsp_last, .rsp_crc_ok,
        .rsp_timeout);
    mms_device i_mms_device (.clock, .reset, .link, .station_id(station), .load_valid,
        .load_coil, .load_addr, .load_value, .fwd_valid, .fwd_coil, .fwd_addr, .fwd_value);
    mms_device i_mms_device_2 (.clock, .reset, .link(link_b), .station_id(station),
        .load_valid, .load_coil, .load_addr, .load_value, .fwd_valid(fwd2_valid),
        .fwd_coil(), .fwd_addr(), .fwd_value());
    mms_link_props i_props (.clock, .reset, .m2s_valid(link.m2s_valid),
        .m2s_data(link.m2s_data), .m2s_last(link.m2s_last), .s2m_valid(link.s2m_valid),
        .s2m_data(link.s2m_data), .s2m_last(link.s2m_last));
    // ------------------------------
    // Tasks
    // ------------------------------
    task automatic check(input string name, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic finish_test;
        if (errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Reflected checksum.
    function automatic logic [15:0] crc16(input mms_byte_t q[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (q[i]) begin
            c = c ^ {8'h00, q[i]};
            for (int b = 0; b < 8; b++) begin
                c = c[0] ? ((c >> 1) ^ 16'ha001) : (c >> 1);
            end
        end
        return c;
    endfunction
    // One command; ack low expects silence.
    task automatic xact(input mms_byte_t st, fn, input logic [15:0] a, v, input bit ack);
        logic [15:0] c;
        bit          wr, hit;
        wr = (fn == 8'h05 || fn == 8'h06);
        hit = 1'b0;
        if (wr) want = '{st, fn, a[15:8], a[7:0], v[15:8], v[7:0]};
        if (!ack) want = {};
        c = crc16(want);
        if (ack) want = {want, c[7:0], c[15:8]};
        got = {};
        do @(posedge clock); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b1;
        cmd_station <= st;
        cmd_func <= fn;
        cmd_addr <= a;
        cmd_value <= v;
        @(posedge clock);
        cmd_valid <= 1'b0;
        // Bounded by the master's own reply timeout.
        for (int i = 0; i < 1100; i++) begin
            @(posedge clock);
            if (fwd_valid === 1'b1) begin
                hit = 1'b1;
                check("fwd_kind", {15'h0, fwd_coil}, {15'h0, fn == 8'h05});
                check("fwd_addr", fwd_addr, a);
                check("fwd_value", fwd_value, v);
            end
            if (rsp_valid === 1'b1) got.push_back(rsp_data);
            if (rsp_last === 1'b1) check("crc_ok", {15'h0, rsp_crc_ok}, 16'h0001);
            if (rsp_last === 1'b1 || rsp_timeout === 1'b1) break;
        end
        check("timeout", {15'h0, rsp_timeout}, {15'h0, !ack});
        check("forwarded", {15'h0, hit}, {15'h0, ack && wr});
        check("length", 16'(got.size()), 16'(want.size()));
        foreach (want[i]) check("reply_byte", {8'h0, got[i]}, {8'h0, want[i]});
    endtask
    // Raw frame on the second link; flip spoils the checksum.
    task automatic raw(input mms_byte_t f[$], input logic [15:0] flip, input int n_exp);
        logic [15:0] c;
        int          n = 0;
        c = crc16(f) ^ flip;
        f = {f, c[7:0], c[15:8]};
        foreach (f[i]) begin
            @(posedge clock);
            link_b.m2s_valid <= 1'b1;
            link_b.m2s_data <= f[i];
            link_b.m2s_last <= (i == 7);
        end
        @(posedge clock);
        link_b.m2s_valid <= 1'b0;
        link_b.m2s_last <= 1'b0;
        link_b.m2s_data <= ~f[7];  // A released line must not keep the last byte.
        repeat (14) begin
            @(posedge clock);
            n += int'(link_b.s2m_valid === 1'b1) + int'(fwd2_valid === 1'b1);
        end
        check("raw_reply", 16'(n), 16'(n_exp));
    endtask
    // Ceiling far above the run's few thousand cycles.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            finish_test;
        end
    end
    initial begin
        link_b.m2s_valid = 1'b0;
        link_b.m2s_data = 8'h00;
        link_b.m2s_last = 1'b0;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        xact(8'h01, 8'h05, 16'h0040, 16'hff00, 1'b1);
        xact(8'h01, 8'h05, 16'h0042, 16'hff00, 1'b1);
        xact(8'h01, 8'h05, 16'h0043, 16'hff00, 1'b1);
        xact(8'h01, 8'h05, 16'h0100, 16'hff00, 1'b1);
        xact(8'h01, 8'h05, 16'h0040, 16'h0000, 1'b1);
        xact(8'h01, 8'h05, 16'h0101, 16'hff00, 1'b0);
        xact(8'h01, 8'h05, 16'h0044, 16'h1234, 1'b0);
        xact(8'h02, 8'h05, 16'h0044, 16'hff00, 1'b0);
        for (int i = 0; i < 3; i++) begin
            @(posedge clock);
            load_valid <= 1'b1;
            load_addr <= 16'h4e20 + 16'(i);
            load_value <= 16'h0014 + 16'(10 * i);
        end
        @(posedge clock);
        load_coil <= 1'b1;
        load_addr <= 16'h0045;
        load_value <= 16'h0007;  // Nonzero sets an entry.
        @(posedge clock);
        load_valid <= 1'b0;
        want = '{8'h01, 8'h01, 8'h02, 8'h2c, 8'h00};
        xact(8'h01, 8'h01, 16'h0040, 16'h000a, 1'b1);
        want = '{8'h01, 8'h01, 8'h01, 8'h01};
        xact(8'h01, 8'h01, 16'h0100, 16'h0001, 1'b1);
        xact(8'h01, 8'h01, 16'h0040, 16'h00c2, 1'b0);
        xact(8'h01, 8'h06, 16'h4e21, 16'h0064, 1'b1);
        want = '{8'h01, 8'h03, 8'h06, 8'h00, 8'h14, 8'h00, 8'h64, 8'h00, 8'h28};
        xact(8'h01, 8'h03, 16'h4e20, 16'h0003, 1'b1);
        want = '{8'h01, 8'h03, 8'h02, 8'h00, 8'h00};
        xact(8'h01, 8'h03, 16'h4e9f, 16'h0001, 1'b1);
        xact(8'h01, 8'h03, 16'h4e20, 16'h007e, 1'b0);
        station <= 8'hf7;
        xact(8'hf7, 8'h06, 16'h4e9f, 16'hbeef, 1'b1);
        raw('{8'hf7, 8'h05, 8'h00, 8'h41, 8'hff, 8'h00}, 16'h0100, 0);
        raw('{8'hf7, 8'h05, 8'h00, 8'h41, 8'hff, 8'h00}, 16'h0001, 0);
        raw('{8'h01, 8'h05, 8'h00, 8'h41, 8'hff, 8'h00}, 16'h0000, 0);
        raw('{8'hf7, 8'h05, 8'h00, 8'h41, 8'hff, 8'h00}, 16'h0000, 9);
        finish_test;
    end
endmodule
